// >>> rtl/sps_regs.vh
`ifndef SPS_REGS_VH
`define SPS_REGS_VH

// queue and program geometry
`define SPS_LINE_W 6
`define SPS_SEG_W 4
`define SPS_WORD_W 16
`define SPS_MAX_LINE 6'h3E
`define SPS_MAX_SEG 4'hC
`define SPS_STACK_DEPTH 3'h5

// host command codes
`define SPS_CMD_KEY 4'h1
`define SPS_CMD_SAVE 4'h2
`define SPS_CMD_DELETE 4'h3
`define SPS_CMD_RUN 4'h4
`define SPS_CMD_LOAD 4'h5
`define SPS_CMD_STORE 4'h6
`define SPS_CMD_UPLOAD 4'h7
`define SPS_CMD_LOADRUN 4'h8
`define SPS_CMD_HALT 4'h9

// queue line word: [15:12] opcode, [8:6] condition, [5:0] line or segment
`define SPS_OP_HI 15
`define SPS_OP_LO 12
`define SPS_CND_HI 8
`define SPS_CND_LO 6
`define SPS_ARG_HI 5
`define SPS_ARG_LO 0
`define SPS_OP_OTHER 4'h0
`define SPS_OP_CALL 4'h1
`define SPS_OP_GOTO 4'h2
`define SPS_OP_JUMP 4'h3
`define SPS_OP_HALT 4'h4
`define SPS_OP_LOADRUN 4'h5

// condition flag positions: T F P G L E U Z
`define SPS_CC_T 0
`define SPS_CC_Z 7
`define SPS_CC_RESET 8'h00

// non-volatile memory operations
`define SPS_NV_READ 2'h0
`define SPS_NV_WRITE 2'h1
`define SPS_NV_ERASE_SEG 2'h2
`define SPS_NV_ERASE_ALL 2'h3

// factory key code "1234" in ASCII
`define SPS_KEY_DEFAULT 32'h31323334

`endif

// >>> rtl/sps_call_stack.v
`timescale 1ns/100ps
`include "sps_regs.vh"

// five-deep stack of {segment, line} return points
module sps_call_stack (
  input wire clk,
  input wire arst_n,
  input wire push,
  input wire pop,
  input wire [9:0] din,
  output wire [9:0] top,
  output wire full,
  output wire empty
);
  reg [9:0] mem [0:4];
  reg [2:0] count_reg;

  assign full = (count_reg == `SPS_STACK_DEPTH);
  assign empty = (count_reg == 3'h0);
  assign top = empty ? 10'h000 : mem[count_reg - 3'h1];

  // entry storage, no reset needed
  always @(posedge clk) begin
    if (push && !full) begin
      mem[count_reg] <= din;
    end
  end

  // depth counter; overflow and underflow requests are dropped
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 3'h0;
    end else if (push && !full) begin
      count_reg <= count_reg + 3'h1;
    end else if (pop && !empty) begin
      count_reg <= count_reg - 3'h1;
    end
  end
endmodule // sps_call_stack

// >>> rtl/sps_sequencer.v
// Overview of operation
// - call pushes return point, loads segment, runs
// - return pops, reloads caller, resumes next line
// - sixth nested call is ignored
// - return with empty stack is ignored
// - delete erases the stored segment
// - run command starts loaded queue at line 1
// - goto jumps; self or past-end target ignored
// - conditional jump only when condition is met
// - eight condition selectors T F P G L E U Z
// - tests and math results update condition code
// - factory key code means no protection
// - new key needs save, acts next power-up
// - locked refuses upload, store and delete only
// - unlock is lost at every power-up
// - default key when locked unlocks, erases all
// - load overwrites queue from line 1
// - halt stops execution, queue kept
`timescale 1ns/100ps
`include "sps_regs.vh"

module sps_sequencer (
  input wire clk,
  input wire arst_n,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [3:0] cmd_code,
  input wire [5:0] cmd_arg,
  input wire cmd_has_arg,
  input wire [31:0] cmd_key,
  output reg cmd_ok,
  output reg cmd_refused,
  input wire line_valid,
  input wire [15:0] line_data,
  input wire [31:0] nv_key,
  output reg key_save_valid,
  output reg [31:0] key_save_data,
  output reg nv_req,
  output reg [1:0] nv_op,
  output reg [3:0] nv_seg,
  output reg [5:0] nv_line,
  output reg [15:0] nv_wdata,
  input wire [15:0] nv_rdata,
  input wire nv_ack,
  input wire nv_end,
  output reg exec_valid,
  output reg [15:0] exec_word,
  input wire exec_done,
  input wire cc_wr,
  input wire [7:0] cc_flags,
  output reg running,
  output reg locked,
  output reg [5:0] cur_line,
  output reg [3:0] cur_seg
);
  localparam S_IDLE = 6'h01;
  localparam S_FETCH = 6'h02;
  localparam S_EXEC = 6'h04;
  localparam S_LOAD = 6'h08;
  localparam S_STORE = 6'h10;
  localparam S_ERASE = 6'h20;

  reg [5:0] state_reg;
  reg boot_done_reg;
  reg [31:0] boot_key_reg;
  reg serial_reg;
  reg [5:0] qlen_reg;
  reg go_run_reg;
  reg [5:0] go_line_reg;
  reg [7:0] cc_reg;
  reg push;
  reg pop;
  reg [15:0] queue [0:63];
  wire [9:0] stk_top;
  wire stk_full;
  wire stk_empty;
  wire [15:0] fw;
  wire [3:0] fop;
  wire [5:0] farg;
  wire ld_wr;
  wire ser_wr;
  wire [5:0] line_inc;

  // segment number in 1..12
  function seg_ok;
    input [5:0] s;
    begin
      seg_ok = (s != 6'h00) && (s <= {2'b00, `SPS_MAX_SEG});
    end
  endfunction

  // jump target legal: not own line, not past queue end
  function tgt_ok;
    input [5:0] t;
    input [5:0] pc;
    input [5:0] len;
    begin
      tgt_ok = (t != 6'h00) && (t != pc) && (t <= len);
    end
  endfunction

  assign fw = queue[cur_line];
  assign fop = fw[`SPS_OP_HI:`SPS_OP_LO];
  assign farg = fw[`SPS_ARG_HI:`SPS_ARG_LO];
  assign line_inc = cur_line + 6'h01;
  assign cmd_ready = boot_done_reg && (state_reg == S_IDLE || state_reg == S_FETCH);
  assign ld_wr = (state_reg == S_LOAD) && nv_req && nv_ack && !nv_end;
  assign ser_wr = serial_reg && line_valid && (qlen_reg < `SPS_MAX_LINE);

  sps_call_stack u_stack (
    .clk(clk),
    .arst_n(arst_n),
    .push(push),
    .pop(pop),
    .din({cur_seg, cur_line}),
    .top(stk_top),
    .full(stk_full),
    .empty(stk_empty)
  );

  // queue writes from stored segment or serial line stream
  always @(posedge clk) begin
    if (ld_wr) begin
      queue[nv_line] <= nv_rdata;
    end else if (ser_wr) begin
      queue[qlen_reg + 6'h01] <= line_data;
    end
  end

  // condition code from tests and math results
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cc_reg <= `SPS_CC_RESET;
    end else if (cc_wr) begin
      cc_reg <= cc_flags;
    end
  end

  // start a segment read into the queue
  task start_load;
    input [3:0] s;
    input run;
    input [5:0] ln;
    begin
      nv_req <= 1'b1;
      nv_op <= `SPS_NV_READ;
      nv_seg <= s;
      nv_line <= 6'h01;
      qlen_reg <= 6'h00;
      cur_seg <= s;
      go_run_reg <= run;
      go_line_reg <= ln;
      serial_reg <= 1'b0;
      state_reg <= S_LOAD;
    end
  endtask

  // start an erase of one segment or of all program memory
  task start_erase;
    input [1:0] op;
    input [3:0] s;
    begin
      nv_req <= 1'b1;
      nv_op <= op;
      nv_seg <= s;
      state_reg <= S_ERASE;
    end
  endtask

  // call-stack strobes for the line being fetched
  always @* begin
    push = 1'b0;
    pop = 1'b0;
    if (state_reg == S_FETCH && !(cmd_valid && cmd_ready) && running &&
        cur_line != 6'h00 && cur_line <= qlen_reg && fop == `SPS_OP_CALL) begin
      if (farg == 6'h00) begin
        pop = !stk_empty;
      end else begin
        push = seg_ok(farg) && !stk_full;
      end
    end
  end

  // command handling and queue execution
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_IDLE;
      boot_done_reg <= 1'b0;
      boot_key_reg <= `SPS_KEY_DEFAULT;
      locked <= 1'b0;
      serial_reg <= 1'b0;
      qlen_reg <= 6'h00;
      go_run_reg <= 1'b0;
      go_line_reg <= 6'h01;
      cmd_ok <= 1'b0;
      cmd_refused <= 1'b0;
      key_save_valid <= 1'b0;
      key_save_data <= `SPS_KEY_DEFAULT;
      nv_req <= 1'b0;
      nv_op <= `SPS_NV_READ;
      nv_seg <= 4'h0;
      nv_line <= 6'h00;
      nv_wdata <= 16'h0000;
      exec_valid <= 1'b0;
      exec_word <= 16'h0000;
      running <= 1'b0;
      cur_line <= 6'h00;
      cur_seg <= 4'h0;
    end else begin
      cmd_ok <= 1'b0;
      cmd_refused <= 1'b0;
      key_save_valid <= 1'b0;
      if (ser_wr) begin
        qlen_reg <= qlen_reg + 6'h01;
      end
      if (!boot_done_reg) begin
        // stored key caught after reset release; unlock never survives
        boot_done_reg <= 1'b1;
        boot_key_reg <= nv_key;
        key_save_data <= nv_key;
        locked <= (nv_key != `SPS_KEY_DEFAULT);
      end else begin
        case (state_reg)
          S_IDLE, S_FETCH: begin
            if (cmd_valid) begin
              // immediate commands take priority over the next line
              cmd_ok <= 1'b1;
              case (cmd_code)
                `SPS_CMD_KEY: begin
                  if (!locked) begin
                    key_save_data <= cmd_key;
                  end else if (cmd_key == boot_key_reg) begin
                    locked <= 1'b0;
                  end else if (cmd_key == `SPS_KEY_DEFAULT) begin
                    locked <= 1'b0;
                    start_erase(`SPS_NV_ERASE_ALL, 4'h0);
                  end else begin
                    cmd_ok <= 1'b0;
                    cmd_refused <= 1'b1;
                  end
                end
                `SPS_CMD_SAVE: begin
                  key_save_valid <= 1'b1;
                end
                `SPS_CMD_DELETE: begin
                  if (locked || !seg_ok(cmd_arg)) begin
                    cmd_ok <= 1'b0;
                    cmd_refused <= 1'b1;
                  end else begin
                    start_erase(`SPS_NV_ERASE_SEG, cmd_arg[3:0]);
                  end
                end
                `SPS_CMD_RUN: begin
                  serial_reg <= 1'b0;
                  running <= 1'b1;
                  cur_line <= 6'h01;
                  state_reg <= S_FETCH;
                end
                `SPS_CMD_LOAD: begin
                  running <= 1'b0;
                  if (!cmd_has_arg) begin
                    serial_reg <= 1'b1;
                    qlen_reg <= 6'h00;
                    cur_seg <= 4'h0;
                    state_reg <= S_IDLE;
                  end else if (seg_ok(cmd_arg)) begin
                    start_load(cmd_arg[3:0], 1'b0, 6'h01);
                  end else begin
                    cmd_ok <= 1'b0;
                    cmd_refused <= 1'b1;
                  end
                end
                `SPS_CMD_STORE: begin
                  serial_reg <= 1'b0;
                  if (locked || !seg_ok(cmd_arg) || qlen_reg == 6'h00) begin
                    cmd_ok <= 1'b0;
                    cmd_refused <= 1'b1;
                  end else begin
                    nv_req <= 1'b1;
                    nv_op <= `SPS_NV_WRITE;
                    nv_seg <= cmd_arg[3:0];
                    nv_line <= 6'h01;
                    nv_wdata <= queue[1];
                    state_reg <= S_STORE;
                  end
                end
                `SPS_CMD_UPLOAD: begin
                  if (locked || running) begin
                    cmd_ok <= 1'b0;
                    cmd_refused <= 1'b1;
                  end
                end
                `SPS_CMD_LOADRUN: begin
                  if (seg_ok(cmd_arg)) begin
                    start_load(cmd_arg[3:0], 1'b1, 6'h01);
                  end else begin
                    cmd_ok <= 1'b0;
                    cmd_refused <= 1'b1;
                  end
                end
                `SPS_CMD_HALT: begin
                  running <= 1'b0;
                  state_reg <= S_IDLE;
                end
                default: begin
                  cmd_ok <= 1'b0;
                  cmd_refused <= 1'b1;
                end
              endcase
            end else if (state_reg == S_FETCH) begin
              if (!running || cur_line == 6'h00 || cur_line > qlen_reg) begin
                running <= 1'b0;
                state_reg <= S_IDLE;
              end else begin
                // buffered commands decoded from the queue
                case (fop)
                  `SPS_OP_CALL: begin
                    if (farg == 6'h00 && !stk_empty) begin
                      start_load(stk_top[9:6], 1'b1, stk_top[5:0] + 6'h01);
                    end else if (farg != 6'h00 && seg_ok(farg) && !stk_full) begin
                      start_load(farg[3:0], 1'b1, 6'h01);
                    end else begin
                      cur_line <= line_inc;
                    end
                  end
                  `SPS_OP_GOTO: begin
                    cur_line <= tgt_ok(farg, cur_line, qlen_reg) ? farg : line_inc;
                  end
                  `SPS_OP_JUMP: begin
                    if (cc_reg[fw[`SPS_CND_HI:`SPS_CND_LO]] &&
                        tgt_ok(farg, cur_line, qlen_reg)) begin
                      cur_line <= farg;
                    end else begin
                      cur_line <= line_inc;
                    end
                  end
                  `SPS_OP_HALT: begin
                    running <= 1'b0;
                    state_reg <= S_IDLE;
                  end
                  `SPS_OP_LOADRUN: begin
                    if (seg_ok(farg)) begin
                      start_load(farg[3:0], 1'b1, 6'h01);
                    end else begin
                      cur_line <= line_inc;
                    end
                  end
                  default: begin
                    exec_valid <= 1'b1;
                    exec_word <= fw;
                    state_reg <= S_EXEC;
                  end
                endcase
              end
            end
          end
          S_EXEC: begin
            // other commands run by the motion engine
            if (exec_done) begin
              exec_valid <= 1'b0;
              cur_line <= line_inc;
              state_reg <= S_FETCH;
            end
          end
          S_LOAD: begin
            if (nv_ack) begin
              if (!nv_end) begin
                qlen_reg <= nv_line;
              end
              if (nv_end || nv_line == `SPS_MAX_LINE) begin
                nv_req <= 1'b0;
                running <= go_run_reg;
                cur_line <= go_line_reg;
                state_reg <= go_run_reg ? S_FETCH : S_IDLE;
              end else begin
                nv_line <= nv_line + 6'h01;
              end
            end
          end
          S_STORE: begin
            if (nv_ack) begin
              if (nv_line == qlen_reg) begin
                nv_req <= 1'b0;
                state_reg <= running ? S_FETCH : S_IDLE;
              end else begin
                nv_line <= nv_line + 6'h01;
                nv_wdata <= queue[nv_line + 6'h01];
              end
            end
          end
          S_ERASE: begin
            if (nv_ack) begin
              nv_req <= 1'b0;
              state_reg <= running ? S_FETCH : S_IDLE;
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule // sps_sequencer

// >>> verif/sps_seq_monitor.sv
`timescale 1ns/100ps
// protocol and sequencing checks on the sequencer ports
module sps_seq_monitor (
  input wire clk,
  input wire arst_n,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [3:0] cmd_code,
  input wire [5:0] cmd_arg,
  input wire cmd_has_arg,
  input wire [31:0] cmd_key,
  input wire cmd_ok,
  input wire cmd_refused,
  input wire nv_req,
  input wire [1:0] nv_op,
  input wire [3:0] nv_seg,
  input wire [5:0] nv_line,
  input wire nv_ack,
  input wire exec_valid,
  input wire [15:0] exec_word,
  input wire exec_done,
  input wire running,
  input wire locked,
  input wire [5:0] cur_line
);
  // command taken and segment number in range
  wire take = cmd_valid && cmd_ready;
  wire seg_ok = (cmd_arg >= 6'h01) && (cmd_arg <= 6'h0C);

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_answer_once: assert property (take |=> cmd_ok != cmd_refused)
    else $error("command answer missing or doubled");
  a_ok_excl: assert property (!(cmd_ok && cmd_refused))
    else $error("accept and refuse together");
  a_delete_erase: assert property (take && cmd_code == 4'h3 && !locked && seg_ok
    |=> cmd_ok && nv_req && nv_op == 2'h2 && nv_seg == $past(cmd_arg[3:0]))
    else $error("delete did not erase the segment");
  a_locked_refuse: assert property (take && locked
    && (cmd_code == 4'h3 || cmd_code == 4'h6 || cmd_code == 4'h7) |=> cmd_refused)
    else $error("protected command accepted while locked");
  a_load_first: assert property (take && cmd_code == 4'h5 && cmd_has_arg && seg_ok
    |=> nv_req && nv_op == 2'h0 && nv_line == 6'h01 && nv_seg == $past(cmd_arg[3:0]))
    else $error("load did not start at line one");
  a_nv_hold: assert property (nv_req && !nv_ack
    |=> nv_req && $stable(nv_op) && $stable(nv_seg) && $stable(nv_line))
    else $error("memory request dropped or changed");
  a_exec_hold: assert property (exec_valid && !exec_done |=> exec_valid && $stable(exec_word))
    else $error("queue line changed before done");
  a_exec_step: assert property (exec_valid && exec_done
    |=> !exec_valid && cur_line == $past(cur_line) + 6'h01)
    else $error("line did not advance by one");
  a_key_default: assert property (take && cmd_code == 4'h1 && locked
    && cmd_key == 32'h31323334 |=> cmd_ok ##[0:2] (nv_req && nv_op == 2'h3))
    else $error("factory key did not erase all");
  a_lock_kept: assert property (locked && !(take && cmd_code == 4'h1) |=> locked)
    else $error("lock dropped without key");
  a_run_first: assert property (take && cmd_code == 4'h4
    |=> cmd_ok ##[0:2] (running && cur_line == 6'h01))
    else $error("run did not start at line one");

  // main scenarios reached
  c_refused: cover property (cmd_refused);
  c_exec: cover property (exec_valid && exec_done);
  c_erase_all: cover property (nv_req && nv_op == 2'h3);
endmodule // sps_seq_monitor

// >>> verif/sps_far_model.sv
`timescale 1ns/100ps
// segment store and motion engine beside the sequencer
module sps_far_model (
  input wire clk,
  input wire arst_n,
  input wire nv_req,
  input wire [1:0] nv_op,
  input wire [3:0] nv_seg,
  input wire [5:0] nv_line,
  input wire [15:0] nv_wdata,
  output reg [15:0] nv_rdata,
  output reg nv_ack,
  output reg nv_end,
  input wire exec_valid,
  output reg exec_done,
  input wire [3:0] dly
);
  reg [15:0] mem [0:15][0:63];
  integer len [0:15];
  integer cnt, ecnt, i;

  // every segment starts empty
  initial for (i = 0; i < 16; i = i + 1) len[i] = 0;

  // answer each request after dly waiting cycles
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nv_ack <= 1'h0;
      nv_end <= 1'h0;
      exec_done <= 1'h0;
      nv_rdata <= 16'h5A5A;
      cnt <= 0;
      ecnt <= 0;
    end else begin
      nv_ack <= 1'h0;
      nv_end <= 1'h0;
      exec_done <= 1'h0;
      nv_rdata <= ~nv_rdata; // no stale data between answers
      if (nv_req && !nv_ack) begin
        cnt <= cnt + 1;
        if (cnt >= dly) begin
          cnt <= 0;
          nv_ack <= 1'h1;
          nv_rdata <= mem[nv_seg][nv_line];
          nv_end <= (nv_op == 2'h0) && (nv_line > len[nv_seg]);
          if (nv_op == 2'h1) begin
            mem[nv_seg][nv_line] <= nv_wdata;
            len[nv_seg] <= nv_line;
          end
          if (nv_op == 2'h2) len[nv_seg] <= 0;
          if (nv_op == 2'h3) for (i = 0; i < 16; i = i + 1) len[i] <= 0;
        end
      end
      if (exec_valid && !exec_done) begin
        ecnt <= ecnt + 1;
        if (ecnt >= dly) begin
          ecnt <= 0;
          exec_done <= 1'h1;
        end
      end
    end
  end
endmodule // sps_far_model

// >>> verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  reg clk, arst_n, cmd_valid, cmd_has_arg, cc_wr, line_valid;
  reg [15:0] line_data;
  reg [3:0] cmd_code, dly;
  reg [5:0] cmd_arg;
  reg [31:0] cmd_key, nv_key, saved;
  reg [7:0] cc_flags;
  wire cmd_ready, cmd_ok, cmd_refused, key_save_valid, nv_req, nv_ack, nv_end;
  wire exec_valid, exec_done, running, locked;
  wire [31:0] key_save_data;
  wire [1:0] nv_op;
  wire [3:0] nv_seg, cur_seg;
  wire [5:0] nv_line, cur_line;
  wire [15:0] nv_wdata, nv_rdata, exec_word;
  integer failures, cmp_count, seed, i, n;
  reg [15:0] got_q[$];
  reg [15:0] exp_q[$];

  sps_sequencer uut (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_has_arg(cmd_has_arg), .cmd_key(cmd_key),
    .cmd_ok(cmd_ok), .cmd_refused(cmd_refused), .line_valid(line_valid), .line_data(line_data),
    .nv_key(nv_key), .key_save_valid(key_save_valid), .key_save_data(key_save_data),
    .nv_req(nv_req), .nv_op(nv_op), .nv_seg(nv_seg), .nv_line(nv_line), .nv_wdata(nv_wdata),
    .nv_rdata(nv_rdata), .nv_ack(nv_ack), .nv_end(nv_end), .exec_valid(exec_valid),
    .exec_word(exec_word), .exec_done(exec_done), .cc_wr(cc_wr), .cc_flags(cc_flags),
    .running(running), .locked(locked), .cur_line(cur_line), .cur_seg(cur_seg));
  sps_far_model fm (.clk(clk), .arst_n(arst_n), .nv_req(nv_req), .nv_op(nv_op),
    .nv_seg(nv_seg), .nv_line(nv_line), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata),
    .nv_ack(nv_ack), .nv_end(nv_end), .exec_valid(exec_valid), .exec_done(exec_done), .dly(dly));

  // 25 MHz clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // record finished queue lines and the key handed out for saving
  always @(posedge clk) begin
    if (exec_valid && exec_done) got_q.push_back(exec_word);
    if (key_save_valid) saved <= key_save_data;
  end

  task check(input [31:0] g, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  task results;
    begin
      $display("failures=%0d comparisons=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask

  // power-up with a given stored key
  task boot(input [31:0] k);
    begin
      @(negedge clk);
      arst_n = 1'h0;
      nv_key = k;
      repeat (10) @(negedge clk);
      arst_n = 1'h1;
      repeat (2) @(negedge clk);
    end
  endtask

  // lets one edge pass, then waits for the command port; a hang counts as a mismatch
  task idle;
    begin
      n = 0;
      @(negedge clk);
      while (!cmd_ready && n < 9000) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n >= 9000) failures = failures + 1;
    end
  endtask

  // one host command, answer checked the cycle after it is taken
  task cmd(input [3:0] c, input [5:0] a, input h, input [31:0] k, input ok);
    begin
      idle;
      cmd_valid = 1'h1;
      cmd_code = c;
      cmd_arg = a;
      cmd_has_arg = h;
      cmd_key = k;
      @(negedge clk);
      cmd_valid = 1'h0;
      check(cmd_ok, ok);
      check(cmd_refused, !ok);
    end
  endtask

  // reference interpreter of the stored program flow
  task automatic model(input integer seg);
    integer ln, w, k, sp;
    integer ss[$];
    integer sl[$];
    begin
      exp_q.delete();
      ln = 1;
      for (k = 0; k < 200; k = k + 1) begin
        w = fm.mem[seg][ln];
        sp = ss.size();
        case (w[15:12])
          4'h1: if (w[5:0] == 0 && sp > 0) begin
            seg = ss.pop_back();
            ln = sl.pop_back() + 1;
          end else if (w[5:0] != 0 && sp < 5) begin
            ss.push_back(seg);
            sl.push_back(ln);
            seg = w[5:0];
            ln = 1;
          end else ln = ln + 1;
          4'h2, 4'h3: if ((w[15:12] == 2 || cc_flags[w[8:6]]) && w[5:0] != ln
            && w[5:0] <= fm.len[seg]) ln = w[5:0];
          else ln = ln + 1;
          4'h4: k = 200;
          default: begin
            exp_q.push_back(w[15:0]);
            ln = ln + 1;
          end
        endcase
      end
    end
  endtask

  // start a program with random condition flags and compare executed lines
  task prog(input [3:0] c, input [5:0] s, input integer ms);
    begin
      cc_flags = $random(seed);
      cc_wr = 1'h1;
      @(negedge clk);
      cc_wr = 1'h0;
      model(ms);
      got_q.delete();
      cmd(c, s, 1'h1, 32'h0, 1'h1);
      n = 0;
      while (!running && n < 9000) begin
        @(negedge clk);
        n = n + 1;
      end
      while (running && n < 9000) begin
        @(negedge clk);
        n = n + 1;
      end
      check(running, 1'h0);
      check(got_q.size(), exp_q.size());
      for (n = 0; n < exp_q.size(); n = n + 1) check(got_q[n], exp_q[n]);
    end
  endtask

  // cuts a hang short after about 50000 cycles, well over the expected run
  initial begin
    #2000000;
    failures = failures + 1;
    results;
  end

  initial begin
    seed = 32'h02AF;
    failures = 0;
    cmp_count = 0;
    arst_n = 1'h0;
    {cmd_valid, cmd_has_arg, cc_wr, line_valid, line_data, cmd_code, cmd_arg, cmd_key} = 0;
    {cc_flags, dly} = 0;
    nv_key = 32'h31323334;
    @(negedge clk);
    {fm.mem[1][1], fm.mem[1][3], fm.mem[1][4], fm.mem[1][5]} = 64'h0A01_0A03_1002_2005;
    {fm.mem[1][6], fm.mem[1][7], fm.mem[1][8]} = 48'h2009_0A07_4000;
    {fm.mem[2][1], fm.mem[2][2], fm.mem[2][3]} = 48'h0B01_1000_4000;
    {fm.mem[3][1], fm.mem[3][2], fm.mem[3][3]} = 48'h0C01_1003_4000;
    {fm.len[1], fm.len[2], fm.len[3], fm.len[5]} = {32'h8, 32'h3, 32'h3, 32'h3};
    boot(32'h31323334);
    check(locked, 1'h0);
    cmd(4'h3, 6'h05, 1'h0, 32'h0, 1'h1);
    idle;
    check(fm.len[5], 0);
    cmd(4'h3, 6'h0D, 1'h0, 32'h0, 1'h0);
    cmd(4'hF, 6'h00, 1'h0, 32'h0, 1'h0);
    // every condition selector, each with a fresh load
    for (i = 0; i < 8; i = i + 1) begin
      fm.mem[1][2] = 16'h3004 | (i << 6);
      dly = $random(seed);
      cmd(4'h5, 6'h01, 1'h1, 32'h0, 1'h1);
      prog(4'h4, 6'h00, 1);
    end
    prog(4'h8, 6'h02, 2);
    prog(4'h8, 6'h03, 3);
    cmd(4'h6, 6'h07, 1'h0, 32'h0, 1'h1);
    idle;
    check(fm.len[7], 3);
    check(fm.mem[7][1], 16'h0C01);
    // serial load of two lines, the second chaining into segment 2 with a full stack
    got_q.delete();
    cmd(4'h5, 6'h00, 1'h0, 32'h0, 1'h1);
    line_valid = 1'h1;
    line_data = 16'h0D01;
    @(negedge clk);
    line_data = 16'h5002;
    @(negedge clk);
    line_valid = 1'h0;
    cmd(4'h4, 6'h00, 1'h0, 32'h0, 1'h1);
    n = 0;
    while (running && n < 9000) begin
      @(negedge clk);
      n = n + 1;
    end
    check(running, 1'h0);
    check(got_q.size(), 2);
    check(got_q[0], 16'h0D01);
    check(got_q[1], 16'h0B01);
    check(cur_seg, 4'h3);
    cmd(4'h1, 6'h00, 1'h0, 32'h616B3939, 1'h1);
    cmd(4'h2, 6'h00, 1'h0, 32'h0, 1'h1);
    idle;
    check(saved, 32'h616B3939);
    check(locked, 1'h0);
    boot(saved);
    check(locked, 1'h1);
    cmd(4'h3, 6'h01, 1'h0, 32'h0, 1'h0);
    cmd(4'h6, 6'h01, 1'h0, 32'h0, 1'h0);
    cmd(4'h7, 6'h01, 1'h0, 32'h0, 1'h0);
    cmd(4'h5, 6'h01, 1'h1, 32'h0, 1'h1);
    cmd(4'h1, 6'h00, 1'h0, 32'h41423132, 1'h0);
    cmd(4'h1, 6'h00, 1'h0, saved, 1'h1);
    idle;
    check(locked, 1'h0);
    cmd(4'h3, 6'h01, 1'h0, 32'h0, 1'h1);
    idle;
    check(fm.len[1], 0);
    boot(saved);
    check(locked, 1'h1);
    cmd(4'h1, 6'h00, 1'h0, 32'h31323334, 1'h1);
    idle;
    check(locked, 1'h0);
    check(fm.len[2], 0);
    results;
  end
endmodule // tb_top

bind sps_sequencer sps_seq_monitor mon (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_has_arg(cmd_has_arg),
  .cmd_key(cmd_key), .cmd_ok(cmd_ok), .cmd_refused(cmd_refused), .nv_req(nv_req),
  .nv_op(nv_op), .nv_seg(nv_seg), .nv_line(nv_line), .nv_ack(nv_ack),
  .exec_valid(exec_valid), .exec_word(exec_word), .exec_done(exec_done),
  .running(running), .locked(locked), .cur_line(cur_line));
